//--- sdi_params.svh
`ifndef SDI_PARAMS_SVH
`define SDI_PARAMS_SVH

`define SDI_ROW_W 13
`define SDI_COL_W 9
`define SDI_BANK_W 2
`define SDI_BANKS 4
`define SDI_DQ_W 16
`define SDI_ALL_BANKS_BIT 10
`define SDI_RD_MASK_LATENCY 2
`define SDI_MODE_RESET 13'h0000
`define SDI_LOW_LANE 0
`define SDI_HIGH_LANE 1

`endif

//--- sdi_pkg.sv
package sdi_pkg;

    typedef enum logic [2:0] {
        SDI_CMD_NOP = 3'h0,
        SDI_CMD_MRS = 3'h1,
        SDI_CMD_ACT = 3'h2,
        SDI_CMD_RD  = 3'h3,
        SDI_CMD_WR  = 3'h4,
        SDI_CMD_PRE = 3'h5,
        SDI_CMD_REF = 3'h6,
        SDI_CMD_BST = 3'h7
    } sdi_cmd_t;

    typedef enum logic [1:0] {
        SDI_PWR_RUN     = 2'h0,
        SDI_PWR_DOWN    = 2'h1,
        SDI_PWR_SUSPEND = 2'h2,
        SDI_PWR_SREF    = 2'h3
    } sdi_pwr_t;

    // Strobes are active low; chip select high is a deselect and decodes as idle
    function automatic sdi_cmd_t sdi_decode(input logic cs_n, input logic ras_n,
                                            input logic cas_n, input logic we_n);
        sdi_cmd_t c;
        c = SDI_CMD_NOP;
        if (!cs_n) begin
            unique case ({ras_n, cas_n, we_n})
                3'h0: c = SDI_CMD_MRS;
                3'h1: c = SDI_CMD_REF;
                3'h2: c = SDI_CMD_PRE;
                3'h3: c = SDI_CMD_ACT;
                3'h4: c = SDI_CMD_WR;
                3'h5: c = SDI_CMD_RD;
                3'h6: c = SDI_CMD_BST;
                3'h7: c = SDI_CMD_NOP;
            endcase
        end
        return c;
    endfunction

endpackage

//--- sdi_lane_if.sv
interface sdi_lane_if;
    logic mask;
    logic rd_valid;
    logic wr_req;
    logic oe_next;
    logic wr_en_next;

    modport lane (input mask, input rd_valid, input wr_req, output oe_next, output wr_en_next);
    modport ctrl (output mask, output rd_valid, output wr_req, input oe_next, input wr_en_next);
endinterface

//--- sdi_byte_lane.sv
`include "sdi_params.svh"

module sdi_byte_lane
    import sdi_pkg::*;
(
    input wire logic clk, // System clock
    input wire logic rst_n, // Async reset, active low
    sdi_lane_if.lane lp // Mask and strobes of one byte lane
);
    logic [`SDI_RD_MASK_LATENCY-1:0] mask_pipe_reg;
    logic [`SDI_RD_MASK_LATENCY-1:0] mask_pipe_next;

    always_comb begin
        mask_pipe_next = {mask_pipe_reg[`SDI_RD_MASK_LATENCY-2:0], lp.mask};
        // Read mask acts on the output two edges after it is sampled
        lp.oe_next = lp.rd_valid & ~mask_pipe_reg[`SDI_RD_MASK_LATENCY-1];
        // Write mask acts on the very edge that sampled it
        lp.wr_en_next = lp.wr_req & ~lp.mask;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mask_pipe_reg <= '1;
        end else begin
            mask_pipe_reg <= mask_pipe_next;
        end
    end
endmodule

//--- sdi_device.sv
`include "sdi_params.svh"

module sdi_device
    import sdi_pkg::*;
#(
    parameter int ROW_W = `SDI_ROW_W,
    parameter int COL_W = `SDI_COL_W,
    parameter int BANK_W = `SDI_BANK_W,
    parameter int BANKS = `SDI_BANKS,
    parameter int DQ_W = `SDI_DQ_W
) (
    input wire logic clk, // System clock, rising edge samples everything
    input wire logic rst_n, // Async reset, active low
    input wire logic cke, // Clock gate, high runs the device
    input wire logic cs_n, // Chip select, active low
    input wire logic ras_n, // Row strobe, active low
    input wire logic cas_n, // Column strobe, active low
    input wire logic we_n, // Write strobe, active low
    input wire logic [ROW_W-1:0] addr, // Multiplexed row and column address
    input wire logic [BANK_W-1:0] bank_select_bits, // Bank select
    input wire logic low_byte_mask, // Mask for data bits 7..0
    input wire logic high_byte_mask, // Mask for data bits 15..8
    input wire logic [DQ_W-1:0] data_pins_in, // Data pins, input level
    input wire logic [DQ_W-1:0] core_rd_data, // Read data from the array
    input wire logic core_rd_valid, // Array read data is due on the pins
    output logic [DQ_W-1:0] data_pins_out, // Data pins, driven level
    output logic [DQ_W-1:0] data_pins_oe, // Data pins, high while driven
    output sdi_cmd_t cmd_out, // Command executed at the last edge
    output logic [BANK_W-1:0] cmd_bank, // Bank of that command
    output logic [ROW_W-1:0] row_addr, // Latched row address
    output logic [COL_W-1:0] col_addr, // Latched column address
    output logic [ROW_W-1:0] mode_value, // Programmed mode register
    output logic [BANKS-1:0] bank_open, // One bit per active bank
    output logic [DQ_W-1:0] wr_data, // Write data for the array
    output logic [1:0] wr_byte_en, // Per-byte write enable for the array
    output sdi_pwr_t pwr_state // Power state
);
    localparam int BYTE_W = DQ_W / 2;

    sdi_cmd_t cmd_reg;
    sdi_cmd_t cmd_next;
    sdi_cmd_t cmd_now;
    sdi_pwr_t pwr_reg;
    sdi_pwr_t pwr_next;
    logic [BANK_W-1:0] bank_reg;
    logic [BANK_W-1:0] bank_next;
    logic [ROW_W-1:0] row_reg;
    logic [ROW_W-1:0] row_next;
    logic [COL_W-1:0] col_reg;
    logic [COL_W-1:0] col_next;
    logic [ROW_W-1:0] mode_reg;
    logic [ROW_W-1:0] mode_next;
    logic [BANKS-1:0] open_reg;
    logic [BANKS-1:0] open_next;
    logic [DQ_W-1:0] dout_reg;
    logic [DQ_W-1:0] dout_next;
    logic [DQ_W-1:0] oe_reg;
    logic [DQ_W-1:0] oe_next;
    logic [DQ_W-1:0] wdata_reg;
    logic [DQ_W-1:0] wdata_next;
    logic [1:0] wben_reg;
    logic [1:0] wben_next;
    logic running;
    logic busy;
    logic all_banks;

    sdi_lane_if lane_bus [2] ();

    assign lane_bus[`SDI_LOW_LANE].mask = low_byte_mask;
    assign lane_bus[`SDI_HIGH_LANE].mask = high_byte_mask;

    generate
        for (genvar i = 0; i < 2; i++) begin : g_lane
            assign lane_bus[i].rd_valid = core_rd_valid & running;
            assign lane_bus[i].wr_req = running && (cmd_now == SDI_CMD_WR);
            sdi_byte_lane u_lane (
                .clk(clk),
                .rst_n(rst_n),
                .lp(lane_bus[i])
            );
            assign oe_next[i*BYTE_W +: BYTE_W] = {BYTE_W{lane_bus[i].oe_next}};
            assign wben_next[i] = lane_bus[i].wr_en_next;
        end
    endgenerate

    // Deselect decodes as idle, so a burst in flight is left alone
    assign cmd_now = sdi_decode(cs_n, ras_n, cas_n, we_n);
    assign running = cke && (pwr_reg == SDI_PWR_RUN);
    // A read still on the pins or a write being taken counts as an access in flight
    assign busy = core_rd_valid || (oe_reg != '0) || (cmd_now == SDI_CMD_WR);

    // Only meaningful at a precharge; the same bit at an access would ask for
    // auto precharge, which is not modelled here
    assign all_banks = addr[`SDI_ALL_BANKS_BIT];

    always_comb begin
        pwr_next = pwr_reg;
        cmd_next = SDI_CMD_NOP;
        bank_next = bank_reg;
        row_next = row_reg;
        col_next = col_reg;
        mode_next = mode_reg;
        open_next = open_reg;
        dout_next = core_rd_valid ? core_rd_data : dout_reg;
        wdata_next = wdata_reg;
        if (pwr_reg != SDI_PWR_RUN) begin
            // Leaving a low-power state wants the clock gate back; no command in that edge
            if (cke) begin
                pwr_next = SDI_PWR_RUN;
            end
        end else if (!cke) begin
            // The state entered depends on what the device is doing
            if (cmd_now == SDI_CMD_REF) begin
                pwr_next = SDI_PWR_SREF;
            end else if (busy) begin
                pwr_next = SDI_PWR_SUSPEND;
            end else begin
                pwr_next = SDI_PWR_DOWN;
            end
        end else begin
            cmd_next = cmd_now;
            unique case (cmd_now)
                SDI_CMD_MRS: begin
                    mode_next = addr;
                end
                SDI_CMD_ACT: begin
                    bank_next = bank_select_bits;
                    row_next = addr;
                    open_next[bank_select_bits] = 1'b1;
                end
                SDI_CMD_RD, SDI_CMD_WR: begin
                    bank_next = bank_select_bits;
                    // Upper address bits are don't-care at an access
                    col_next = addr[COL_W-1:0];
                    if (cmd_now == SDI_CMD_WR) begin
                        wdata_next = data_pins_in;
                    end
                end
                SDI_CMD_PRE: begin
                    bank_next = bank_select_bits;
                    if (all_banks) begin
                        open_next = '0;
                    end else begin
                        open_next[bank_select_bits] = 1'b0;
                    end
                end
                SDI_CMD_REF: begin
                    // Refresh counting lives in the array; nothing to latch here
                end
                SDI_CMD_BST: begin
                    // Burst logic sits outside, so a stop only shows on cmd_out
                end
                SDI_CMD_NOP: begin
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pwr_reg <= SDI_PWR_RUN;
            cmd_reg <= SDI_CMD_NOP;
            bank_reg <= '0;
            row_reg <= '0;
            col_reg <= '0;
            mode_reg <= `SDI_MODE_RESET;
            open_reg <= '0;
            dout_reg <= '0;
            oe_reg <= '0;
            wdata_reg <= '0;
            wben_reg <= '0;
        end else begin
            pwr_reg <= pwr_next;
            cmd_reg <= cmd_next;
            bank_reg <= bank_next;
            row_reg <= row_next;
            col_reg <= col_next;
            mode_reg <= mode_next;
            open_reg <= open_next;
            dout_reg <= dout_next;
            oe_reg <= oe_next;
            wdata_reg <= wdata_next;
            wben_reg <= wben_next;
        end
    end

    assign data_pins_out = dout_reg;
    assign data_pins_oe = oe_reg;
    assign cmd_out = cmd_reg;
    assign cmd_bank = bank_reg;
    assign row_addr = row_reg;
    assign col_addr = col_reg;
    assign mode_value = mode_reg;
    assign bank_open = open_reg;
    assign wr_data = wdata_reg;
    assign wr_byte_en = wben_reg;
    assign pwr_state = pwr_reg;
endmodule

//--- sdi_device_props.sv
module sdi_device_props
    import sdi_pkg::*;
(
    input wire logic clk, // Clock
    input wire logic rst_n, // Reset
    input wire logic cke, // Clock gate
    input wire logic cs_n, // Select
    input wire logic ras_n, // Row strobe
    input wire logic cas_n, // Column strobe
    input wire logic we_n, // Write strobe
    input wire logic [12:0] addr, // Address
    input wire logic [1:0] bank_select_bits, // Bank
    input wire logic low_byte_mask, // Low mask
    input wire logic high_byte_mask, // High mask
    input wire logic [15:0] data_pins_in, // Data in
    input wire logic core_rd_valid, // Read valid
    input wire logic [15:0] data_pins_oe, // Drive enables
    input sdi_cmd_t cmd_out, // Command
    input wire logic [1:0] cmd_bank, // Bank
    input wire logic [12:0] row_addr, // Row
    input wire logic [12:0] mode_value, // Mode
    input wire logic [3:0] bank_open, // Open banks
    input wire logic [15:0] wr_data, // Write data
    input wire logic [1:0] wr_byte_en, // Byte enables
    input sdi_pwr_t pwr_state // Power state
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    logic go;
    logic [2:0] st;
    assign go = cke && !cs_n && pwr_state == SDI_PWR_RUN;
    assign st = {ras_n, cas_n, we_n};
    a_deselect_ignored: assert property (cs_n |=> cmd_out == SDI_CMD_NOP)
        else $error("command taken while deselected");
    a_act_latched: assert property (go && st == 3'h3 |=> cmd_out == SDI_CMD_ACT
        && row_addr == $past(addr) && cmd_bank == $past(bank_select_bits))
        else $error("activate not latched");
    a_precharge_all: assert property (go && st == 3'h2 && addr[10] |=> bank_open == 4'h0)
        else $error("all-bank precharge left a bank open");
    a_write_masked: assert property (go && st == 3'h4 |=> cmd_out == SDI_CMD_WR
        && wr_byte_en == ~{$past(high_byte_mask), $past(low_byte_mask)}
        && wr_data == $past(data_pins_in)) else $error("write byte enables wrong");
    // Six steady edges so a wake-up edge never sits inside the mask pipeline
    a_read_float: assert property (cke [*6] |-> data_pins_oe ==
        {{8{$past(core_rd_valid) && !$past(high_byte_mask, 3)}},
        {8{$past(core_rd_valid) && !$past(low_byte_mask, 3)}}}) else $error("read mask latency");
    a_mode_set: assert property (go && st == 3'h0 |=> mode_value == $past(addr))
        else $error("mode value not taken");
    a_power_entry: assert property (!cke && pwr_state == SDI_PWR_RUN |=>
        pwr_state != SDI_PWR_RUN && cmd_out == SDI_CMD_NOP) else $error("no low-power entry");
    a_power_exit: assert property (cke && pwr_state != SDI_PWR_RUN |=>
        pwr_state == SDI_PWR_RUN && cmd_out == SDI_CMD_NOP) else $error("bad wake-up");
    c_mode: cover property (go && st == 3'h0);
    c_act: cover property (go && st == 3'h3);
    c_sleep: cover property (!cke && pwr_state == SDI_PWR_RUN);
endmodule

bind sdi_device sdi_device_props u_props (.*);

//--- sdi_ctrl_model.sv
module sdi_ctrl_model
    import sdi_pkg::*;
(
    input sdi_cmd_t op, // Command to place
    input wire logic sel, // Chip select wanted
    output logic cs_n, // Select
    output logic [2:0] st // Row, column, write strobes
);
    timeunit 1ns;
    timeprecision 100ps;
    // Idle is all strobes high, so an unset op never starts anything
    always_comb begin
        cs_n = !sel;
        case (op)
            SDI_CMD_MRS: st = 3'h0;
            SDI_CMD_REF: st = 3'h1;
            SDI_CMD_PRE: st = 3'h2;
            SDI_CMD_ACT: st = 3'h3;
            SDI_CMD_WR: st = 3'h4;
            SDI_CMD_RD: st = 3'h5;
            default: st = 3'h7;
        endcase
    end
endmodule

//--- sdi_device_tb.sv
module sdi_device_tb;
    import sdi_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;
    typedef struct {sdi_cmd_t c; logic [17:0] v;} sdi_note_t;
    localparam int GAP = 3;
    logic clk = 1'h0, rst_n = 1'h0, cke = 1'h1, sel = 1'h1, lm = 1'h1, hm = 1'h1;
    logic rv = 1'h0, chk_oe = 1'h0, cs_n, vv;
    logic [1:0] a1 = 2'h3, a2 = 2'h3, cb, be, bs = 2'h0;
    logic [2:0] st;
    logic [8:0] ca;
    logic [12:0] addr = 13'h0, ra, mv, r;
    logic [15:0] din = 16'h0, rd = 16'h0, oe, wd, d, dd, dq;
    logic [3:0] bo;
    sdi_cmd_t op = SDI_CMD_NOP, co;
    sdi_pwr_t ps, pe;
    int miscompares = 0, cmp_count = 0, cyc = 0, s;
    sdi_note_t q[$];
    always #5 clk = ~clk;
    sdi_ctrl_model u_ctrl (.op(op), .sel(sel), .cs_n(cs_n), .st(st));
    sdi_device u_dut (.clk(clk), .rst_n(rst_n), .cke(cke), .cs_n(cs_n), .ras_n(st[2]),
        .cas_n(st[1]), .we_n(st[0]), .addr(addr), .bank_select_bits(bs), .low_byte_mask(lm),
        .high_byte_mask(hm), .data_pins_in(din), .core_rd_data(rd), .core_rd_valid(rv),
        .data_pins_out(dq), .data_pins_oe(oe), .cmd_out(co), .cmd_bank(cb), .row_addr(ra),
        .col_addr(ca), .mode_value(mv), .bank_open(bo), .wr_data(wd), .wr_byte_en(be),
        .pwr_state(ps));
    task automatic chk(string n, logic [17:0] e, logic [17:0] g);
        cmp_count++;
        if (g !== e) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic conclude;
        if (q.size() != 0) chk("notes left", 18'h0, 18'(q.size()));
        $display("counts: %0d compared, %0d wrong", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic issue(sdi_cmd_t c, logic [1:0] b, logic [12:0] a, logic [17:0] v);
        op <= c;
        bs <= b;
        addr <= a;
        q.push_back('{c, v});
        @(posedge clk);
    endtask
    task automatic idle(int n);
        op <= SDI_CMD_NOP;
        repeat (n) @(posedge clk);
    endtask
    function automatic logic [17:0] pay(sdi_cmd_t c);
        case (c)
            SDI_CMD_ACT: return {3'h0, cb, ra};
            SDI_CMD_RD: return {7'h0, cb, ca};
            SDI_CMD_WR: return {be, wd};
            SDI_CMD_MRS: return {5'h0, mv};
            SDI_CMD_PRE: return {14'h0, bo};
            default: return 18'h0;
        endcase
    endfunction
    always @(posedge clk) begin
        sdi_note_t n;
        logic [1:0] cur;
        cur = {hm, lm};
        vv = rv;
        dd = rd;
        #1;
        if (chk_oe) chk("oe", {2'h0, {8{vv & ~a2[1]}}, {8{vv & ~a2[0]}}}, {2'h0, oe});
        if (chk_oe && vv) chk("read data", {2'h0, dd}, {2'h0, dq});
        a2 = a1;
        a1 = cur;
        if (co !== SDI_CMD_NOP) begin
            if (q.size() == 0) chk("unasked command", 18'h0, {15'h0, co});
            else begin
                n = q.pop_front();
                chk("cmd", {15'h0, n.c}, {15'h0, co});
                chk("result", n.v, pay(co));
            end
        end
        cyc++;
        if (cyc == 2000) begin
            miscompares++;
            conclude();
        end
    end
    initial begin
        s = $urandom(30656);
        repeat (2) @(posedge clk);
        rst_n <= 1'h1;
        idle(20);
        issue(SDI_CMD_PRE, 2'h0, 13'h0400, 18'h0);
        repeat (8) issue(SDI_CMD_REF, 2'h0, 13'h0, 18'h0);
        r = 13'($urandom);
        issue(SDI_CMD_MRS, 2'h0, r, {5'h0, r});
        idle(GAP);
        $display("test init done");
        for (int b = 0; b < 4; b++) begin
            r = 13'($urandom);
            issue(SDI_CMD_ACT, 2'(b), r, {3'h0, 2'(b), r});
            idle(GAP);
        end
        for (int b = 0; b < 4; b++) begin
            d = 16'($urandom);
            r = {4'h0, 9'($urandom)};
            din <= d;
            {hm, lm} <= 2'(b);
            issue(SDI_CMD_WR, 2'(b), r, {~2'(b), d});
            issue(SDI_CMD_RD, 2'(b), r, {7'h0, 2'(b), r[8:0]});
        end
        issue(SDI_CMD_PRE, 2'h1, 13'h0, 18'hd);
        idle(GAP);
        issue(SDI_CMD_ACT, 2'h1, r, {3'h0, 2'h1, r});
        issue(SDI_CMD_PRE, 2'h2, 13'h0400, 18'h0);
        $display("test banks done");
        sel <= 1'h0;
        op <= SDI_CMD_ACT;
        repeat (3) @(posedge clk);
        sel <= 1'h1;
        issue(SDI_CMD_PRE, 2'h0, 13'h0, 18'h0);
        idle(1);
        $display("test deselect done");
        chk_oe <= 1'h1;
        rv <= 1'h1;
        repeat (10) begin
            {hm, lm} <= 2'($urandom);
            rd <= 16'($urandom);
            @(posedge clk);
        end
        rv <= 1'h0;
        idle(4);
        chk_oe <= 1'h0;
        $display("test read mask done");
        for (int k = 0; k < 3; k++) begin
            // Idle, refresh strobes and write strobes pick the three low-power states
            op <= (k == 1) ? SDI_CMD_REF : (k == 2) ? SDI_CMD_WR : SDI_CMD_NOP;
            cke <= 1'h0;
            @(posedge clk);
            idle(3);
            pe = (k == 1) ? SDI_PWR_SREF : (k == 2) ? SDI_PWR_SUSPEND : SDI_PWR_DOWN;
            chk("power", {16'h0, pe}, {16'h0, ps});
            // The activate at the wake-up edge must be ignored
            op <= SDI_CMD_ACT;
            cke <= 1'h1;
            @(posedge clk);
            idle(1);
            chk("power", {16'h0, SDI_PWR_RUN}, {16'h0, ps});
        end
        $display("test power done");
        conclude();
    end
endmodule
